// ### rtl/hps_pkg.sv
// Package of constants for the shared host port pin block
`default_nettype none
package hps_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int RAM_AW = 18;
   // Register map (word offsets on the plain register port)
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_ADDR = 4'h2;
   // Control register fields
   localparam int CTRL_KEEP_BIT = 0;
   localparam logic CTRL_KEEP_RST = 1'h0;
   // Status register fields
   localparam int STAT_HOST_BIT = 0;
   localparam int STAT_MUX_BIT = 1;
   localparam int STAT_FLOAT_BIT = 2;
   localparam int STAT_KEEP_BIT = 3;
endpackage : hps_pkg
`default_nettype wire

// ### rtl/hps_host_port.sv
// Host port pin sharing with external memory interface and bus keepers
// Operation
// - Pins serve host only when select low
// - Data bus bidirectional, host writes, device reads
// - Keepers hold last driven level when idle
// - Keepers off at reset, one control bit
// - Float input low tri-states all data pins
//
// Chosen here: the address map and strobed register access.
`default_nettype none
module hps_host_port
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic port_function_select,
   input wire logic addr_mux_select,
   input wire logic float_n,
   input wire logic [17:0] host_addr_in,
   input wire logic [15:0] host_data_in,
   output logic [15:0] host_data_out,
   output logic [15:0] host_data_oe,
   output logic [15:0] host_data_keep,
   input wire logic host_chip_select_n,
   input wire logic host_addr_strobe_n,
   input wire logic host_data_strobe_n,
   input wire logic host_read_write,
   input wire logic [17:0] ext_mem_addr_src,
   input wire logic [15:0] ext_mem_wdata,
   input wire logic ext_mem_wr,
   output logic [17:0] ext_mem_addr,
   output logic [15:0] ext_mem_data_out,
   output logic ext_mem_data_oe,
   output logic [15:0] ext_mem_rdata,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic keep_en;
      logic [17:0] addr;
      logic [15:0] last;
      logic [15:0] dout;
      logic [15:0] oe;
      logic [15:0] keep;
      logic ds_prev;
      logic [17:0] xaddr;
      logic [15:0] xdout;
      logic xoe;
      logic [15:0] xrd;
      logic [15:0] rdata;
   } hps_state_t;

   hps_state_t s_q;
   hps_state_t s_d;
   logic [15:0] ram [0:(1 << hps_pkg::RAM_AW) - 1];
   logic host_mode;
   logic xfer_start;
   logic [17:0] xfer_addr;
   logic [15:0] ram_rd;

   assign host_mode = !port_function_select;
   assign xfer_start = host_mode && !host_chip_select_n
      && !host_data_strobe_n && s_q.ds_prev;
   assign xfer_addr = addr_mux_select ? host_addr_in : s_q.addr;
   assign ram_rd = ram[xfer_addr];

   // ---------------------------------------------------------------
   // Host RAM write
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (xfer_start && !host_read_write)
      begin
         ram[xfer_addr] <= host_data_in;
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.ds_prev = host_data_strobe_n;
      if (host_mode && !addr_mux_select && !host_chip_select_n
         && !host_addr_strobe_n)
      begin
         s_d.addr = host_addr_in;
      end
      if (s_q.oe == 16'h0000)
      begin
         s_d.dout = s_q.last;
      end
      if (xfer_start && host_read_write && float_n)
      begin
         s_d.dout = ram_rd;
         s_d.last = ram_rd;
      end
      // Device drives only for a host read in host mode
      if (host_mode && float_n && !host_chip_select_n
         && !host_data_strobe_n && host_read_write)
      begin
         s_d.oe = 16'hffff;
      end
      else
      begin
         s_d.oe = 16'h0000;
      end
      if (!float_n)
      begin
         s_d.keep = 16'h0000;
      end
      else
      begin
         s_d.keep = {16{s_q.keep_en}};
      end
      // External memory interface owns pins when select high
      s_d.xaddr = host_mode ? 18'h00000 : ext_mem_addr_src;
      s_d.xoe = !host_mode && ext_mem_wr && float_n;
      s_d.xdout = ext_mem_wdata;
      if (!host_mode && !s_q.xoe)
      begin
         s_d.xrd = host_data_in;
      end
      if (reg_wr && reg_addr == hps_pkg::OFS_CTRL)
      begin
         s_d.keep_en = reg_wdata[hps_pkg::CTRL_KEEP_BIT];
      end
      s_d.rdata = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            hps_pkg::OFS_CTRL:
               s_d.rdata[hps_pkg::CTRL_KEEP_BIT] = s_q.keep_en;
            hps_pkg::OFS_STATUS:
            begin
               s_d.rdata[hps_pkg::STAT_HOST_BIT] = host_mode;
               s_d.rdata[hps_pkg::STAT_MUX_BIT] = addr_mux_select;
               s_d.rdata[hps_pkg::STAT_FLOAT_BIT] = !float_n;
               s_d.rdata[hps_pkg::STAT_KEEP_BIT] = s_q.keep[0];
            end
            hps_pkg::OFS_ADDR:
               s_d.rdata = s_q.addr[15:0];
            default:
               s_d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.keep_en <= hps_pkg::CTRL_KEEP_RST;
         s_q.ds_prev <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign host_data_out = s_q.dout;
   assign host_data_oe = s_q.oe;
   assign host_data_keep = s_q.keep;
   assign ext_mem_addr = s_q.xaddr;
   assign ext_mem_data_out = s_q.xdout;
   assign ext_mem_data_oe = s_q.xoe;
   assign ext_mem_rdata = s_q.xrd;
   assign reg_rdata = s_q.rdata;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_float_tristate: assert property (
      @(posedge clk_sys) disable iff (rst)
      !float_n |=> host_data_oe == 16'h0000 && !ext_mem_data_oe)
      else $error("data pins driven while float asserted");
   a_share_host: assert property (
      @(posedge clk_sys) disable iff (rst)
      port_function_select |=> host_data_oe == 16'h0000)
      else $error("host data driven in memory mode");
   a_share_mem: assert property (
      @(posedge clk_sys) disable iff (rst)
      !port_function_select |=> !ext_mem_data_oe
      && ext_mem_addr == 18'h00000)
      else $error("memory interface active in host mode");
   a_keep_reset: assert property (
      @(posedge clk_sys)
      rst |=> host_data_keep == 16'h0000)
      else $error("keepers not off after reset");
   a_keep_ctrl: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_wr && reg_addr == hps_pkg::OFS_CTRL && float_n
      ##1 float_n |=> host_data_keep
      == {16{$past(reg_wdata[hps_pkg::CTRL_KEEP_BIT], 2)}})
      else $error("keeper control bit not applied");
   a_keep_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      host_data_oe == 16'h0000 && $past(host_data_oe) == 16'h0000
      |-> $stable(host_data_out))
      else $error("idle data level moved");
   a_read_drive: assert property (
      @(posedge clk_sys) disable iff (rst)
      !port_function_select && float_n && !host_chip_select_n
      && !host_data_strobe_n && host_read_write
      |=> host_data_oe == 16'hffff)
      else $error("host read not driven");
   a_addr_latch: assert property (
      @(posedge clk_sys) disable iff (rst)
      !port_function_select && !addr_mux_select && !host_chip_select_n
      && !host_addr_strobe_n |=> s_q.addr == $past(host_addr_in))
      else $error("address strobe did not latch");
   c_mem_drive: cover property (@(posedge clk_sys) disable iff (rst)
      ext_mem_data_oe);
   c_host_read: cover property (@(posedge clk_sys) disable iff (rst)
      host_data_oe == 16'hffff);
   c_float: cover property (@(posedge clk_sys) disable iff (rst) !float_n);
   c_keep_on: cover property (@(posedge clk_sys) disable iff (rst)
      host_data_keep == 16'hffff);
endmodule : hps_host_port
`default_nettype wire

// ### verif/hps_host_model.sv
// Host processor model driving the host port strobes
`default_nettype none
module hps_host_model
(
   input wire logic clk_sys,
   output logic cs_n,
   output logic as_n,
   output logic ds_n,
   output logic rw,
   output logic [17:0] addr,
   output logic [15:0] dat,
   output logic drv
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Transfers
   // ----------
   initial {cs_n, as_n, ds_n, rw, addr, dat, drv} = {4'hf, 35'h0};
   task automatic xfer(input logic r, input logic m, input logic [17:0] a,
      input logic [15:0] d);
      @(posedge clk_sys);
      cs_n <= 1'h0;
      rw <= r;
      addr <= a;
      dat <= m ? a[15:0] : d;
      drv <= m | !r;
      as_n <= !m;
      @(posedge clk_sys);
      as_n <= 1'h1;
      dat <= d;
      drv <= !r;
      ds_n <= 1'h0;
      repeat (3) @(posedge clk_sys);
      {cs_n, ds_n, drv} <= 3'h6;
      addr <= ~a;
   endtask : xfer
endmodule : hps_host_model
`default_nettype wire

// ### verif/hps_host_port_tb_top.sv
// Self-checking bench for the shared host port block
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module hps_host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, sel, mux, flt_n, cs_n, as_n, ds_n, rw, drv, wr, rd;
   logic ewr, xoe;
   logic [17:0] ha, ea, a, xad;
   logic [15:0] xdo, xrd;
   logic [101:0] memq[$], e102;
   logic [15:0] hd, pin, last_q = 0, dout, oe, keep, rdata, wd, ewd, d;
   logic [3:0] ra;
   logic [31:0] seed = 32'h48, e32;
   logic [63:0] hostq[$], e64;
   logic [31:0] regq[$];
   logic [1:0] ds_cnt = 0;
   logic rd_p = 0;
   int num_errors = 0, samples_checked = 0, cyc = 0;
   // ----------
   // Harness
   // ----------
   assign pin = (oe & dout) | (~oe & (drv ? hd : ~(keep ^ last_q)));
   hps_host_port u_hps_host_port (.clk_sys(clk_sys), .rst(rst),
      .port_function_select(sel), .addr_mux_select(mux), .float_n(flt_n),
      .host_addr_in(ha), .host_data_in(pin), .host_data_out(dout),
      .host_data_oe(oe), .host_data_keep(keep), .host_chip_select_n(cs_n),
      .host_addr_strobe_n(as_n), .host_data_strobe_n(ds_n),
      .host_read_write(rw), .ext_mem_addr_src(ea), .ext_mem_wdata(ewd),
      .ext_mem_wr(ewr), .ext_mem_addr(xad), .ext_mem_data_out(xdo),
      .ext_mem_data_oe(xoe), .ext_mem_rdata(xrd), .reg_addr(ra),
      .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
   hps_host_model u_hps_host_model (.clk_sys(clk_sys), .cs_n(cs_n),
      .as_n(as_n), .ds_n(ds_n), .rw(rw), .addr(ha), .dat(hd), .drv(drv));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic reg_op(input logic w, input logic [3:0] ad,
      input logic [15:0] dv, input logic [31:0] e);
      @(posedge clk_sys);
      ra <= ad;
      wd <= dv;
      wr <= w;
      rd <= !w;
      if (!w) regq.push_back(e);
      @(posedge clk_sys);
      {wr, rd} <= 2'h0;
   endtask : reg_op
   task automatic host(input logic r, input logic m, input logic [17:0] ad,
      input logic [15:0] dv, input logic [63:0] e);
      hostq.push_back(e);
      u_hps_host_model.xfer(r, m, ad, dv);
   endtask : host
   task automatic final_report();
      if (num_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   always @(posedge clk_sys)
   begin
      last_q <= pin;
      ds_cnt <= (ds_n | cs_n) ? 2'h0 : ds_cnt + 2'h1;
      rd_p <= rd;
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         num_errors++;
         final_report();
      end
   end
   always @(negedge clk_sys)
   begin
      if (ds_cnt == 2'h2 && hostq.size() > 0)
      begin
         e64 = hostq.pop_front();
         `CHK({oe, dout} & e64[63:32], e64[31:0])
      end
      if (ds_cnt == 2'h2 && sel && memq.size() > 0)
      begin
         e102 = memq.pop_front();
         `CHK({xoe, xdo, xad, xrd} & e102[101:51], e102[50:0])
      end
      if (rd_p && regq.size() > 0)
      begin
         e32 = regq.pop_front();
         `CHK({keep, rdata}, e32)
      end
   end
   initial
   begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ----------
   // Scenarios
   // ----------
   initial
   begin
      {rst, sel, mux, flt_n, wr, rd, ewr, ra, wd, ewd, ea} = {7'h58, 54'h0};
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      reg_op(1'h0, hps_pkg::OFS_CTRL, 16'h0, 32'h0);
      reg_op(1'h1, hps_pkg::OFS_CTRL, 16'h1, 32'h0);
      reg_op(1'h0, hps_pkg::OFS_CTRL, 16'h0, 32'hffff_0001);
      reg_op(1'h0, 4'hf, 16'h0, 32'hffff_0000);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         a = seed[17:0];
         d = seed[31:16];
         ewd <= d;
         ea <= ~a;
         host(1'h0, 1'h0, a, d, {32'hffff_0000, 32'h0});
         host(1'h1, 1'h0, a, 16'h0, {32'hffff_ffff, 16'hffff, d});
      end
      mux <= 1'h0;
      host(1'h0, 1'h1, 18'h05a3c, 16'hc35a, {32'hffff_0000, 32'h0});
      reg_op(1'h0, hps_pkg::OFS_ADDR, 16'h0, 32'hffff_5a3c);
      mux <= 1'h1;
      host(1'h1, 1'h0, 18'h05a3c, 16'h0, {32'hffff_ffff, 32'hffff_c35a});
      flt_n <= 1'h0;
      host(1'h1, 1'h0, a, 16'h0, {32'hffff_0000, 32'h0});
      flt_n <= 1'h1;
      sel <= 1'h1;
      ewr <= 1'h1;
      memq.push_back({51'h7_ffff_ffff_0000, 1'h1, d, ~a, 16'h0});
      host(1'h1, 1'h0, a, 16'h0, {32'hffff_0000, 32'h0});
      ewr <= 1'h0;
      memq.push_back({51'h4_0000_0000_ffff, 35'h0, ~d});
      host(1'h0, 1'h0, a, ~d, {32'hffff_0000, 32'h0});
      sel <= 1'h0;
      host(1'h1, 1'h0, a, 16'h0, {32'hffff_ffff, 16'hffff, d});
      reg_op(1'h1, hps_pkg::OFS_CTRL, 16'h0, 32'h0);
      reg_op(1'h0, hps_pkg::OFS_CTRL, 16'h0, 32'h0);
      repeat (3) @(posedge clk_sys);
      final_report();
   end
endmodule : hps_host_port_tb_top
`default_nettype wire
